// ==== logic/irq_chain_pkg.sv ====
// constants and types for the backplane interrupter and its acknowledge chain
// assumes a single 125 MHz core clock and synchronous active-high reset
//
// Summary of operation
// - request by pulling the assigned one of seven active-low request lines low.
// - shared request lines are fine; only the chain decides who is acknowledged.
// - a requesting interrupter waits for its own chain input low before accepting.
// - the accepting interrupter holds its chain output high for that cycle.
// - chain input low alone is never taken as an acknowledge.
// - acknowledge needs address modifier 0x27 on the modifier lines.
// - pass chain low onward when idle or when the level does not match.
// - respond only when the level on the lowest three address lines matches.
// - drive status/ID on the low eight data lines, then assert transfer acknowledge.
`default_nettype none
package irq_chain_pkg;

    localparam logic [5:0] ack_modifier_code = 6'h27;
    localparam int         am_width          = 6;
    localparam int         level_width       = 3;
    localparam int         status_width      = 8;
    localparam int         request_lines     = 7;

    // data setup time before transfer acknowledge, in ns and in cycles
    localparam int         clk_period_ns     = 8;
    localparam int         data_setup_ns     = 16;
    localparam int         data_setup_cycles =
        (data_setup_ns + clk_period_ns - 1) / clk_period_ns;

    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_pending = 3'b001,
        st_pass    = 3'b010,
        st_setup   = 3'b011,
        st_answer  = 3'b100,
        st_release = 3'b101
    } chain_state_e;

endpackage
`default_nettype wire

// ==== logic/sync_two_flop.sv ====
// two-flop synchroniser for backplane pins
// assumes inputs may change at any time relative to core_clk
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop #(
    parameter int width = 1,
    parameter logic [width-1:0] reset_value = '0
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // data
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] sync_out
);
    logic [width-1:0] meta;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta     <= reset_value;
            sync_out <= reset_value;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== logic/backplane_interrupt_ack_chain.sv ====
// interrupter end of the backplane interrupt bus with acknowledge daisy chain
// assumes all bus inputs are asynchronous and open-collector lines are
// resolved outside from the output enables
`timescale 1ns/10ps
`default_nettype none
module backplane_interrupt_ack_chain
    import irq_chain_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // local side
    input  wire logic                    raise_request,
    input  wire logic [level_width-1:0]  request_level,
    input  wire logic [status_width-1:0] status_id,
    output logic                         request_busy,
    output logic                         status_read,
    // interrupt request lines, open collector
    output logic [request_lines-1:0]     interrupt_request_lines_out,
    output logic [request_lines-1:0]     interrupt_request_lines_oe,
    // data transfer bus, active-low lines except the address modifier
    input  wire logic                    addr_strobe_n,
    input  wire logic                    data_strobe0_n,
    input  wire logic [am_width-1:0]     addr_modifier,
    input  wire logic [level_width-1:0]  ack_level_address_lines_n,
    output logic [status_width-1:0]      status_id_data_lines_out,
    output logic [status_width-1:0]      status_id_data_lines_oe,
    output logic                         transfer_acknowledge_out,
    output logic                         transfer_acknowledge_oe,
    // acknowledge daisy chain
    input  wire logic                    ack_chain_in_n,
    output logic                         ack_chain_out_n
);
    import irq_chain_pkg::*;

    localparam int sync_w = 3 + am_width + level_width;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [sync_w-1:0] raw_in;
    logic [sync_w-1:0] sync_in;
    logic              as_low;
    logic              ds_low;
    logic              chain_low;
    logic [am_width-1:0]    am_s;
    logic [level_width-1:0] lvl_s;

    assign raw_in = {addr_strobe_n, data_strobe0_n, ack_chain_in_n,
                     addr_modifier, ack_level_address_lines_n};

    sync_two_flop #(
        .width       (sync_w),
        .reset_value ({3'b111, {(am_width + level_width){1'b0}}})
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    assign as_low    = ~sync_in[sync_w-1];
    assign ds_low    = ~sync_in[sync_w-2];
    assign chain_low = ~sync_in[sync_w-3];
    assign am_s      = sync_in[level_width +: am_width];
    // address lines are active low on the backplane
    assign lvl_s     = ~sync_in[level_width-1:0];

    // ************************************************************
    // acknowledge decode
    // ************************************************************
    chain_state_e           state;
    logic [level_width-1:0] held_level;
    logic [status_width-1:0] held_status;
    logic [1:0]             setup_cnt;
    logic                   ack_cycle;
    logic                   level_match;

    // modifier and strobes must qualify the chain, never the chain alone
    assign ack_cycle   = as_low && ds_low && chain_low
                         && (am_s == ack_modifier_code);
    assign level_match = (lvl_s == held_level);

    function automatic logic [request_lines-1:0] level_onehot(
        input logic [level_width-1:0] lvl
    );
        level_onehot = '0;
        if (lvl != 3'h0) begin
            level_onehot[lvl - 3'h1] = 1'b1;
        end
    endfunction

    // ************************************************************
    // request and acknowledge sequencer
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state       <= st_idle;
            held_level  <= 3'h0;
            held_status <= 8'h00;
            setup_cnt   <= 2'h0;
        end else begin
            case (state)
                st_idle: begin
                    if (raise_request && request_level != 3'h0) begin
                        held_level  <= request_level;
                        held_status <= status_id;
                        state       <= st_pending;
                    end
                end
                st_pending: begin
                    // accept only after our own chain input goes low
                    if (ack_cycle && level_match) begin
                        setup_cnt <= 2'(data_setup_cycles);
                        state     <= st_setup;
                    end else if (ack_cycle) begin
                        state <= st_pass;
                    end
                end
                st_pass: begin
                    if (!chain_low) begin
                        state <= st_pending;
                    end
                end
                st_setup: begin
                    if (setup_cnt <= 2'h1) begin
                        state <= st_answer;
                    end else begin
                        setup_cnt <= setup_cnt - 2'h1;
                    end
                end
                st_answer: begin
                    if (!as_low || !ds_low) begin
                        state <= st_release;
                    end
                end
                st_release: begin
                    if (!chain_low) begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // ************************************************************
    // bus drivers
    // ************************************************************
    logic pass_low;

    // pass the low onward when idle or on a level mismatch
    assign pass_low = chain_low && (state == st_idle || state == st_pass
                      || (state == st_pending && !(ack_cycle && level_match)
                          && ack_cycle));

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_chain_out_n <= 1'b1;
        end else begin
            // accepting module keeps its output high, blocking downstream
            ack_chain_out_n <= ~pass_low;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            interrupt_request_lines_oe <= 7'h00;
        end else if (state == st_pending || state == st_pass
                     || state == st_setup || state == st_answer) begin
            interrupt_request_lines_oe <= level_onehot(held_level);
        end else begin
            interrupt_request_lines_oe <= 7'h00;
        end
    end
    assign interrupt_request_lines_out = 7'h00;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_id_data_lines_out <= 8'h00;
            status_id_data_lines_oe  <= 8'h00;
            transfer_acknowledge_oe  <= 1'b0;
        end else begin
            if (state == st_setup || state == st_answer) begin
                status_id_data_lines_out <= ~held_status;
                status_id_data_lines_oe  <= 8'hff;
            end else begin
                status_id_data_lines_oe  <= 8'h00;
            end
            transfer_acknowledge_oe <= (state == st_answer) && as_low
                                       && ds_low;
        end
    end
    assign transfer_acknowledge_out = 1'b0;

    assign request_busy = (state != st_idle);
    assign status_read  = (state == st_answer) && (!as_low || !ds_low);

    // ************************************************************
    // checks
    // ************************************************************
    AST_NO_ACK_WITHOUT_CODE: assert property (@(posedge core_clk) disable iff (srst)
        $rose(transfer_acknowledge_oe) |-> $past(am_s, 2) == ack_modifier_code)
        else $error("acknowledge answered without the acknowledge code");
    AST_CHAIN_BLOCKED: assert property (@(posedge core_clk) disable iff (srst)
        state == st_setup |=> ack_chain_out_n)
        else $error("chain passed while accepting");
    AST_WAIT_CHAIN: assert property (@(posedge core_clk) disable iff (srst)
        state == st_pending && !chain_low |=> state != st_setup)
        else $error("accepted without chain input low");
    AST_LEVEL_MATCH: assert property (@(posedge core_clk) disable iff (srst)
        state == st_pending && ack_cycle && !level_match |=> state == st_pass)
        else $error("mismatched level not passed");
    AST_PASS_ON: assert property (@(posedge core_clk) disable iff (srst)
        state == st_idle && chain_low |=> !ack_chain_out_n)
        else $error("idle interrupter did not pass the chain");
    AST_DATA_BEFORE_TRANSFER_ACKNOWLEDGE: assert property (@(posedge core_clk) disable iff (srst)
        $rose(transfer_acknowledge_oe) |-> $past(status_id_data_lines_oe) == 8'hff)
        else $error("transfer acknowledge before data valid");
    AST_REQ_DRIVEN: assert property (@(posedge core_clk) disable iff (srst)
        state == st_pending |=> interrupt_request_lines_oe == level_onehot(held_level))
        else $error("request line not driven while pending");
    AST_CHAIN_ALONE: assert property (@(posedge core_clk) disable iff (srst)
        state == st_pending && chain_low && am_s != ack_modifier_code
        |=> state == st_pending)
        else $error("chain low alone taken as acknowledge");
    AST_RELEASE: assert property (@(posedge core_clk) disable iff (srst)
        state == st_release |=> interrupt_request_lines_oe == 7'h00)
        else $error("request line held after status read");
endmodule
`default_nettype wire

// ==== sim/irq_handler_model.sv ====
// interrupt handler model: one acknowledge cycle for each go pulse
// assumes the bench resolves the open-collector lines, one core_clk
`timescale 1ns/10ps
`default_nettype none
module irq_handler_model
    import irq_chain_pkg::*;
(
    // clock and command
    input  wire logic                    core_clk,
    input  wire logic                    go,
    input  wire logic [am_width-1:0]     am_code,
    input  wire logic [level_width-1:0]  level,
    input  wire logic [3:0]              hold,
    // backplane
    input  wire logic                    transfer_acknowledge_low,
    input  wire logic [status_width-1:0] data_lines,
    input  wire logic [request_lines-1:0] irq_n,
    output logic                         as_n,
    output logic                         ds0_n,
    output logic [am_width-1:0]          am,
    output logic [level_width-1:0]       lvl_n,
    output logic                         chain_n,
    // result
    output logic                         done,
    output logic                         got_ack,
    output logic [status_width-1:0]      read_byte,
    output logic [level_width-1:0]       top_level
);
    int n;
    // ****************************************
    // request prioritiser
    // ****************************************
    // later lines overwrite earlier ones, so the highest-numbered low line wins
    always_comb begin
        top_level = '0;
        for (int i = 0; i < request_lines; i++) begin
            if (!irq_n[i]) begin
                top_level = 3'(i + 1);
            end
        end
    end
    // ****************************************
    // acknowledge sequence
    // ****************************************
    initial begin
        {as_n, ds0_n, chain_n, done, got_ack} = 5'h1c;
        am = '0;
        lvl_n = '0;
        read_byte = '0;
        forever begin
            @(posedge core_clk);
            if (go) begin
                am      <= am_code;
                lvl_n   <= ~level;
                as_n    <= 1'b0;
                ds0_n   <= 1'b0;
                chain_n <= 1'b0;
                got_ack <= 1'b0;
                n = 0;
                while (!transfer_acknowledge_low && n < 40) begin
                    @(posedge core_clk);
                    n++;
                end
                if (transfer_acknowledge_low) begin
                    got_ack   <= 1'b1;
                    read_byte <= ~data_lines;
                    repeat (hold) @(posedge core_clk);
                end
                // undriven lines show the inverse, never the stale value
                {as_n, ds0_n, chain_n} <= 3'h7;
                am    <= ~am_code;
                lvl_n <= level;
                repeat (8) @(posedge core_clk);
                done <= 1'b1;
                @(posedge core_clk);
                done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/test_backplane_interrupt_ack_chain.sv ====
// self-checking bench for the interrupter and its acknowledge chain
// assumes irq_handler_model as the far side, lines pulled up
`timescale 1ns/10ps
`default_nettype none
module test_backplane_interrupt_ack_chain;
    import irq_chain_pkg::*;
    logic core_clk, srst, raise_request, go, done, got_ack, busy, rd;
    logic as_n, ds0_n, chain_n, chain_out_n, dt_out, dt_oe;
    logic low_seen, read_seen;
    logic [3:0]               hold;
    logic [level_width-1:0]   request_level, lvl_n, lvl, top_level;
    logic [status_width-1:0]  status_id, d_out, d_oe, d_lines, read_byte;
    logic [request_lines-1:0] irq_out, irq_oe, irq_n, e;
    logic [am_width-1:0]      am, am_code;
    int n_mismatch, checks, cycles;
    assign irq_n   = ~(irq_oe & ~irq_out);
    assign d_lines = ~(d_oe & ~d_out);
    backplane_interrupt_ack_chain u_backplane_interrupt_ack_chain (
        .core_clk(core_clk), .srst(srst), .raise_request(raise_request),
        .request_level(request_level), .status_id(status_id),
        .request_busy(busy), .status_read(rd),
        .interrupt_request_lines_out(irq_out),
        .interrupt_request_lines_oe(irq_oe), .addr_strobe_n(as_n),
        .data_strobe0_n(ds0_n), .addr_modifier(am),
        .ack_level_address_lines_n(lvl_n),
        .status_id_data_lines_out(d_out), .status_id_data_lines_oe(d_oe),
        .transfer_acknowledge_out(dt_out), .transfer_acknowledge_oe(dt_oe),
        .ack_chain_in_n(chain_n), .ack_chain_out_n(chain_out_n));
    irq_handler_model u_irq_handler_model (
        .core_clk(core_clk), .go(go), .am_code(am_code), .level(lvl),
        .hold(hold), .transfer_acknowledge_low(dt_oe & ~dt_out), .data_lines(d_lines),
        .irq_n(irq_n), .top_level(top_level),
        .as_n(as_n), .ds0_n(ds0_n), .am(am), .lvl_n(lvl_n),
        .chain_n(chain_n), .done(done), .got_ack(got_ack),
        .read_byte(read_byte));
    // ****************************************
    // clock, monitors and shared tasks
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (chain_out_n === 1'b0) low_seen <= 1'b1;
        if (rd === 1'b1) read_seen <= 1'b1;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task ack(input logic [5:0] c, input logic [2:0] l, input logic [3:0] h);
        int k;
        low_seen = 1'b0;
        read_seen = 1'b0;
        @(posedge core_clk);
        {am_code, lvl, hold, go} <= {c, l, h, 1'b1};
        @(posedge core_clk);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 200) begin
            @(posedge core_clk);
            k++;
        end
        check("handler done", done, 1);
    endtask
    task raise(input logic [2:0] l, input logic [7:0] id);
        @(posedge core_clk);
        {raise_request, request_level, status_id} <= {1'b1, l, id};
        @(posedge core_clk);
        raise_request <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 e = ~(7'h01 << (l - 3'h1));
        check("request lines", irq_n, e);
        check("handler top level", top_level, l);
        check("busy", busy, 1);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_refusals;
        raise(3'h3, 8'h5a);
        ack(6'h2d, 3'h3, 4'h0);
        check("wrong modifier ack", got_ack, 0);
        check("held after refusal", irq_n, 7'h7b);
        ack(6'h27, 3'h6, 4'h0);
        check("mismatch ack", got_ack, 0);
        check("mismatch passes chain", low_seen, 1);
        ack(6'h27, 3'h3, 4'h5);
        check("match ack", got_ack, 1);
        check("status byte", read_byte, 8'h5a);
        check("chain held high", low_seen, 0);
        check("status read", read_seen, 1);
        #1 check("request released", irq_n, 7'h7f);
        check("idle", busy, 0);
        $display("test refusals done");
    endtask
    task t_pass;
        // level zero names no line, so nothing may be requested
        @(posedge core_clk);
        {raise_request, request_level} <= {1'b1, 3'h0};
        @(posedge core_clk);
        raise_request <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 check("level zero ignored", busy, 0);
        check("no line for level zero", irq_n, 7'h7f);
        ack(6'h27, 3'h2, 4'h0);
        check("idle ack", got_ack, 0);
        check("idle passes chain", low_seen, 1);
        #1 check("chain out back high", chain_out_n, 1);
        $display("test pass done");
    endtask
    task t_levels;
        for (int l = 1; l <= 7; l++) begin
            raise(3'(l), 8'h80 | 8'(l));
            ack(6'h27, 3'(l), 4'h1);
            check("level ack", got_ack, 1);
            check("level byte", read_byte, 8'h80 | 8'(l));
            #1 check("level released", irq_n, 7'h7f);
        end
        $display("test levels done");
    endtask
    initial begin
        {srst, raise_request, request_level, status_id} = {1'b1, 11'h000};
        {go, am_code, lvl, hold, low_seen, read_seen} = '0;
        {n_mismatch, checks, cycles} = '0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1 check("reset irq oe", irq_oe, 0);
        check("reset chain out", chain_out_n, 1);
        check("reset transfer_acknowledge oe", dt_oe, 0);
        t_refusals();
        t_pass();
        t_levels();
        end_of_test();
    end
endmodule
`default_nettype wire
